// [hdl/cmtc_timer.sv]
// Purpose: Up-counter with two compares, clear select, clock select and contention
// Assumes: ref_clk 200 MHz; trigger and external clock pins are asynchronous
// Notes: Every bus access takes three states; waitrequest drops in the third
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module cmtc_timer
   import cmtc_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [CMTC_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [CMTC_DW-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [CMTC_DW-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic trigger_input_pin,
   input wire logic extClkPin,
   output logic timerOut,
   output logic irq
);
   cmtc_phase_t phase_ff;
   logic [7:0] timer_control_zero_ff, timer_control_one_ff, timer_status_reg_ff;
   logic [7:0] outSel_ff, irqMask_ff;
   logic [CNT_W-1:0] up_counter_ff, compare_reg_a_ff, compare_reg_b_ff;
   logic [PRESCALE_W-1:0] prescale_ff;
   logic [1:0] trigSync_ff, extSync_ff;
   logic trigPrev_ff, extPrev_ff, srcPrev_ff, run_ff, eqA_ff, eqB_ff, timerOut_ff;
   logic [CMTC_DW-1:0] readData_ff;
   logic busStep, wrStep, rdStep, wrCounter, wrCmpA, wrCmpB;
   logic [1:0] clearSel;
   logic [2:0] clockSel;
   logic trigRise, srcLevel, srcFall, extRise, extFall, countTick;
   logic eqA, eqB, matchA, matchB, clearHit, overflow;
   logic [2:0] events;
   logic [CNT_W-1:0] nxt_counter;
   logic nxt_out;

   // Bus decode
   function automatic logic hit(input logic [CMTC_AW-1:0] a, input logic [5:0] ofs);
      hit = (a == ofs);
   endfunction

   assign busStep = avs_read | avs_write;
   assign wrStep = avs_write & avs_byteenable[0] & (phase_ff == PH_T3);
   assign rdStep = avs_read & (phase_ff == PH_T2);
   assign avs_waitrequest = busStep & (phase_ff != PH_T3);
   assign avs_readdata = readData_ff;
   assign wrCounter = wrStep & hit(avs_address, OFS_COUNTER);
   assign wrCmpA = wrStep & hit(avs_address, OFS_CMP_A);
   assign wrCmpB = wrStep & hit(avs_address, OFS_CMP_B);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         phase_ff <= PH_T1;
      end else if (busStep) begin
         unique case (phase_ff)
            PH_T1: phase_ff <= PH_T2;
            PH_T2: phase_ff <= PH_T3;
            PH_T3: phase_ff <= PH_T1;
            default: phase_ff <= PH_T1;
         endcase
      end else begin
         phase_ff <= PH_T1;
      end
   end

   // Read data is captured in the second state so it stands from flops in the third
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         readData_ff <= '0;
      end else if (rdStep) begin
         readData_ff <= '0;
         unique case (avs_address)
            OFS_CTRL_ZERO: readData_ff[7:0] <= timer_control_zero_ff;
            OFS_CTRL_ONE: readData_ff[7:0] <= timer_control_one_ff;
            OFS_STATUS: readData_ff[7:0] <= timer_status_reg_ff;
            OFS_COUNTER: readData_ff[CNT_W-1:0] <= up_counter_ff;
            OFS_CMP_A: readData_ff[CNT_W-1:0] <= compare_reg_a_ff;
            OFS_CMP_B: readData_ff[CNT_W-1:0] <= compare_reg_b_ff;
            OFS_OUT_SEL: readData_ff[7:0] <= outSel_ff;
            OFS_IRQ_MASK: readData_ff[7:0] <= irqMask_ff;
            default: readData_ff <= '0;
         endcase
      end
   end

   // Software control registers
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         timer_control_zero_ff <= RST_REG;
         timer_control_one_ff <= RST_REG;
         outSel_ff <= RST_REG;
         irqMask_ff <= RST_MASK;
      end else if (wrStep) begin
         if (hit(avs_address, OFS_CTRL_ZERO)) timer_control_zero_ff <= avs_writedata[7:0];
         if (hit(avs_address, OFS_CTRL_ONE)) timer_control_one_ff <= avs_writedata[7:0] & 8'h03;
         if (hit(avs_address, OFS_OUT_SEL)) outSel_ff <= avs_writedata[7:0] & 8'h0F;
         if (hit(avs_address, OFS_IRQ_MASK)) irqMask_ff <= avs_writedata[7:0] & STATUS_MASK;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         compare_reg_a_ff <= RST_CMP[CNT_W-1:0];
         compare_reg_b_ff <= RST_CMP[CNT_W-1:0];
      end else begin
         if (wrCmpA) compare_reg_a_ff <= avs_writedata[CNT_W-1:0];
         if (wrCmpB) compare_reg_b_ff <= avs_writedata[CNT_W-1:0];
      end
   end

   // Pin synchronisers; only the second stage is looked at
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         trigSync_ff <= 2'h0;
         extSync_ff <= 2'h0;
         trigPrev_ff <= 1'b0;
         extPrev_ff <= 1'b0;
      end else begin
         trigSync_ff <= {trigSync_ff[0], trigger_input_pin};
         extSync_ff <= {extSync_ff[0], extClkPin};
         trigPrev_ff <= trigSync_ff[1];
         extPrev_ff <= extSync_ff[1];
      end
   end
   assign trigRise = trigSync_ff[1] & ~trigPrev_ff;
   assign extRise = extSync_ff[1] & ~extPrev_ff;
   assign extFall = ~extSync_ff[1] & extPrev_ff;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) prescale_ff <= '0;
      else prescale_ff <= prescale_ff + 1'b1;
   end

   // Source level: internal taps, or the pin, inverted for rising-edge counting
   assign clockSel = timer_control_zero_ff[BIT_CKS_HI -: 3];
   always_comb begin
      srcLevel = 1'b1;
      unique case ({clockSel, timer_control_one_ff[BIT_INT_CLK_SEL]})
         4'h2: srcLevel = prescale_ff[0];
         4'h3: srcLevel = prescale_ff[1];
         4'h4: srcLevel = prescale_ff[2];
         4'h5: srcLevel = prescale_ff[3];
         4'h6: srcLevel = prescale_ff[4];
         4'h7: srcLevel = prescale_ff[5];
         4'h8: srcLevel = prescale_ff[6];
         4'h9: srcLevel = prescale_ff[7];
         4'hA, 4'hB: srcLevel = ~extSync_ff[1];
         4'hC, 4'hD: srcLevel = extSync_ff[1];
         default: srcLevel = 1'b1;
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) srcPrev_ff <= 1'b1;
      else srcPrev_ff <= srcLevel;
   end
   // Any high-to-low step of the selected level counts, including a source switch
   assign srcFall = srcPrev_ff & ~srcLevel;
   assign countTick = run_ff & ((clockSel == 3'h7) ? (extRise | extFall) : srcFall);

   // Trigger enable: counting waits for a trigger edge, free running otherwise
   assign clearSel = timer_control_zero_ff[BIT_CLR_HI -: 2];
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         run_ff <= 1'b1;
      // The write goes first, else the old enable value would hide a fresh enable
      end else if (wrStep && hit(avs_address, OFS_CTRL_ONE)) begin
         run_ff <= ~avs_writedata[BIT_TRIG_EN];
      end else if (!timer_control_one_ff[BIT_TRIG_EN]) begin
         run_ff <= 1'b1;
      end else if (trigRise) begin
         run_ff <= 1'b1;
      end
   end

   // Matches fire once when equality is reached; a compare write masks it
   assign eqA = (up_counter_ff == compare_reg_a_ff);
   assign eqB = (up_counter_ff == compare_reg_b_ff);
   assign matchA = eqA & ~eqA_ff & ~wrCmpA;
   assign matchB = eqB & ~eqB_ff & ~wrCmpB;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         eqA_ff <= 1'b0;
         eqB_ff <= 1'b0;
      end else begin
         eqA_ff <= eqA & ~wrCmpA;
         eqB_ff <= eqB & ~wrCmpB;
      end
   end

   always_comb begin
      unique case (clearSel)
         CLR_NONE: clearHit = 1'b0;
         CLR_MATCH_A: clearHit = matchA;
         CLR_MATCH_B: clearHit = matchB;
         CLR_TRIGGER: clearHit = trigRise;
         default: clearHit = 1'b0;
      endcase
   end
   assign overflow = countTick & ~clearHit & ~wrCounter & (&up_counter_ff);

   always_comb begin
      nxt_counter = up_counter_ff;
      if (clearHit) nxt_counter = '0;
      else if (wrCounter) nxt_counter = avs_writedata[CNT_W-1:0];
      else if (countTick) nxt_counter = up_counter_ff + 1'b1;
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) up_counter_ff <= '0;
      else up_counter_ff <= nxt_counter;
   end

   // Output resolution when both compares hit together
   function automatic logic has(input logic [1:0] a, input logic [1:0] b, input logic [1:0] v);
      has = (a == v) | (b == v);
   endfunction
   always_comb begin
      logic [1:0] actA, actB;
      actA = matchA ? outSel_ff[1:0] : OUT_KEEP;
      actB = matchB ? outSel_ff[3:2] : OUT_KEEP;
      nxt_out = timerOut_ff;
      if (has(actA, actB, OUT_TOGGLE)) nxt_out = ~timerOut_ff;
      else if (has(actA, actB, OUT_HIGH)) nxt_out = 1'b1;
      else if (has(actA, actB, OUT_LOW)) nxt_out = 1'b0;
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) timerOut_ff <= 1'b0;
      else timerOut_ff <= nxt_out;
   end
   assign timerOut = timerOut_ff;

   // Status flags: a new event wins over a write-one clear in the same cycle
   assign events = {matchB, matchA, overflow};
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         timer_status_reg_ff <= RST_REG;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (events[i]) begin
               timer_status_reg_ff[BIT_OVF_FLAG+i] <= 1'b1;
            end else if (wrStep && hit(avs_address, OFS_STATUS)
                         && avs_writedata[BIT_OVF_FLAG+i]) begin
               timer_status_reg_ff[BIT_OVF_FLAG+i] <= 1'b0;
            end
         end
      end
   end

   // Level request, dropped as soon as flag, enable or mask goes away
   assign irq = |(timer_status_reg_ff & timer_control_zero_ff & irqMask_ff
                  & STATUS_MASK);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence s_access_start;
      busStep && phase_ff == PH_T1;
   endsequence
   sequence s_two_waits;
      avs_waitrequest [*2] ##1 !avs_waitrequest;
   endsequence
   a_bus_three_states: assert property (s_access_start |-> s_two_waits)
      else $error("access did not end in its third state");
   a_clear_beats_write: assert property (wrCounter && clearHit |=> up_counter_ff == '0)
      else $error("counter write not discarded on clear");
   a_write_beats_count: assert property (
      wrCounter && !clearHit && countTick
      |=> up_counter_ff == $past(avs_writedata[CNT_W-1:0]))
      else $error("counter write lost to increment");
   a_cmp_write_mask: assert property (
      wrCmpA && !timer_status_reg_ff[BIT_MATCH_A_FLAG]
      |=> !timer_status_reg_ff[BIT_MATCH_A_FLAG])
      else $error("match A flagged during compare write");
   a_cmpb_write_mask: assert property (
      wrCmpB && !timer_status_reg_ff[BIT_MATCH_B_FLAG]
      |=> !timer_status_reg_ff[BIT_MATCH_B_FLAG])
      else $error("match B flagged during compare write");
   a_clear_on_match: assert property (
      clearSel == CLR_MATCH_B && matchB |=> up_counter_ff == '0)
      else $error("no clear on match B");
   a_clear_match_a: assert property (
      clearSel == CLR_MATCH_A && matchA |=> up_counter_ff == '0)
      else $error("no clear on match A");
   a_trigger_clear: assert property (
      clearSel == CLR_TRIGGER && $rose(trigSync_ff[1]) |=> up_counter_ff == '0)
      else $error("no clear on trigger edge");
   a_stopped_holds: assert property (
      !run_ff && !clearHit && !wrCounter |=> up_counter_ff == $past(up_counter_ff))
      else $error("counter moved while waiting for trigger");
   a_write_third_state: assert property (
      avs_write && avs_byteenable[0] && !avs_waitrequest && avs_address == OFS_CMP_A
      |=> compare_reg_a_ff == $past(avs_writedata[CNT_W-1:0]))
      else $error("compare write did not land in third state");
   a_no_early_write: assert property (
      avs_write && avs_waitrequest
      |=> $stable(compare_reg_a_ff) && $stable(timer_control_zero_ff))
      else $error("register changed before third state");
   a_fall_increments: assert property (
      run_ff && clockSel != 3'h7 && srcFall && !clearHit && !wrCounter
      |=> up_counter_ff == $past(up_counter_ff) + 1'b1)
      else $error("falling source edge did not count");
   a_switch_counts: assert property (
      run_ff && clockSel != 3'h7 && $past(srcLevel) && !srcLevel && !clearHit && !wrCounter
      |=> up_counter_ff != $past(up_counter_ff))
      else $error("source switch to low did not count");
   a_toggle_wins: assert property (
      matchA && matchB && (outSel_ff[1:0] == OUT_TOGGLE || outSel_ff[3:2] == OUT_TOGGLE)
      |=> timerOut != $past(timerOut))
      else $error("toggle lost priority");
   a_high_beats_low: assert property (
      matchA && matchB && outSel_ff[1:0] != OUT_TOGGLE && outSel_ff[3:2] != OUT_TOGGLE
      && (outSel_ff[1:0] == OUT_HIGH || outSel_ff[3:2] == OUT_HIGH) |=> timerOut)
      else $error("drive high lost to drive low");
   a_ovf_raises_irq: assert property (
      overflow && timer_control_zero_ff[BIT_OVF_IE] && irqMask_ff[BIT_OVF_FLAG]
      ##1 timer_control_zero_ff[BIT_OVF_IE] && irqMask_ff[BIT_OVF_FLAG] |-> irq)
      else $error("overflow did not interrupt");
   a_matchb_irq: assert property (
      matchB && timer_control_zero_ff[BIT_MATCH_B_IE] && irqMask_ff[BIT_MATCH_B_FLAG]
      ##1 timer_control_zero_ff[BIT_MATCH_B_IE] && irqMask_ff[BIT_MATCH_B_FLAG] |-> irq)
      else $error("match B did not interrupt");
   a_matcha_irq: assert property (
      matchA && timer_control_zero_ff[BIT_MATCH_A_IE] && irqMask_ff[BIT_MATCH_A_FLAG]
      ##1 timer_control_zero_ff[BIT_MATCH_A_IE] && irqMask_ff[BIT_MATCH_A_FLAG] |-> irq)
      else $error("match A did not interrupt");
   a_irq_needs_enable: assert property (
      irq |-> (timer_status_reg_ff[7] && timer_control_zero_ff[7])
      || (timer_status_reg_ff[6] && timer_control_zero_ff[6])
      || (timer_status_reg_ff[5] && timer_control_zero_ff[5]))
      else $error("interrupt without flag and enable");
endmodule

// [hdl/cmtc_pkg.sv]
// Purpose: Shared constants for the compare match timer control block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one register per word
// Notes: Only the low byte of each register is used; upper bits read as zero
package cmtc_pkg;
   localparam int CMTC_AW = 6;
   localparam int CMTC_DW = 32;
   // Register byte offsets
   localparam logic [5:0] OFS_CTRL_ZERO = 6'h00;
   localparam logic [5:0] OFS_CTRL_ONE = 6'h04;
   localparam logic [5:0] OFS_STATUS = 6'h08;
   localparam logic [5:0] OFS_COUNTER = 6'h0C;
   localparam logic [5:0] OFS_CMP_A = 6'h10;
   localparam logic [5:0] OFS_CMP_B = 6'h14;
   localparam logic [5:0] OFS_OUT_SEL = 6'h18;
   localparam logic [5:0] OFS_IRQ_MASK = 6'h1C;
   // Control zero fields
   localparam int BIT_MATCH_B_IE = 7;
   localparam int BIT_MATCH_A_IE = 6;
   localparam int BIT_OVF_IE = 5;
   localparam int BIT_CLR_HI = 4;
   localparam int BIT_CLR_LO = 3;
   localparam int BIT_CKS_HI = 2;
   // Control one fields
   localparam int BIT_TRIG_EN = 1;
   localparam int BIT_INT_CLK_SEL = 0;
   // Status fields share the interrupt enable positions
   localparam int BIT_MATCH_B_FLAG = 7;
   localparam int BIT_MATCH_A_FLAG = 6;
   localparam int BIT_OVF_FLAG = 5;
   localparam logic [7:0] STATUS_MASK = 8'hE0;
   // Counter clear selections
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_MATCH_A = 2'h1;
   localparam logic [1:0] CLR_MATCH_B = 2'h2;
   localparam logic [1:0] CLR_TRIGGER = 2'h3;
   // Compare output actions
   localparam logic [1:0] OUT_KEEP = 2'h0;
   localparam logic [1:0] OUT_LOW = 2'h1;
   localparam logic [1:0] OUT_HIGH = 2'h2;
   localparam logic [1:0] OUT_TOGGLE = 2'h3;
   // Reset values
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] RST_CMP = 8'hFF;
   localparam logic [7:0] RST_MASK = 8'hE0;
   localparam int PRESCALE_W = 8;
   // Bus cycle states; the write lands in the third
   typedef enum logic [2:0] {
      PH_T1 = 3'b001,
      PH_T2 = 3'b010,
      PH_T3 = 3'b100
   } cmtc_phase_t;
endpackage

// [test/tb_top.sv]
// Purpose: Self-checking bench for the compare match timer control block
// Assumes: Every bus access lasts three states; waitrequest is settled before each rising edge
// Notes: Count checks allow a small margin for prescaler phase and source switching
`timescale 1ns/1ps
module tb_top
   import cmtc_pkg::*;
;
   localparam logic [7:0] RST_V [9] = '{RST_REG, RST_REG, RST_REG, RST_REG, RST_CMP, RST_CMP,
      RST_REG, RST_MASK, 8'h00};
   localparam logic [7:0] FLAGS_V [3] = '{8'hC0, 8'h40, 8'hE0};
   localparam logic [7:0] LIMIT_V [3] = '{8'h08, 8'h04, 8'hFF};
   localparam logic [7:0] IE_V [3] = '{8'h80, 8'h40, 8'h20};
   localparam logic [7:0] OSEL_V [3] = '{8'h06, 8'h0D, 8'h0B};
   localparam logic [7:0] OUT_V [3] = '{8'h01, 8'h00, 8'h01};
   logic refClk = 1'h0;
   logic rst = 1'h1;
   logic [CMTC_AW-1:0] addr = '0;
   logic rd = 1'h0;
   logic wr = 1'h0;
   logic [CMTC_DW-1:0] wdata = '0;
   logic [3:0] be = 4'hF;
   logic [CMTC_DW-1:0] rdata;
   logic waitReq;
   logic trig = 1'h0;
   logic extClk = 1'h0;
   logic tOut;
   logic irq;
   logic [7:0] q;
   int errors = 0;
   int checked = 0;
   int cycles = 0;

   cmtc_timer u_cmtc_timer (.ref_clk(refClk), .reset(rst), .avs_address(addr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
      .avs_readdata(rdata), .avs_waitrequest(waitReq), .trigger_input_pin(trig),
      .extClkPin(extClk), .timerOut(tOut), .irq(irq));

   always #2.5 refClk = ~refClk;

   always @(posedge refClk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         $display("unexpected at %0t: run did not complete", $time);
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Just after an edge, waitrequest and read data still show their sampled values;
   // only the bench timeout ends a stalled access
   task automatic xfer(input logic [5:0] a, input logic w, input logic [7:0] d);
      @(posedge refClk);
      addr <= a;
      wdata <= {24'h000000, d};
      wr <= w;
      rd <= ~w;
      @(posedge refClk);
      while (waitReq !== 1'h0) begin
         @(posedge refClk);
      end
      q = rdata[7:0];
      wr <= 1'h0;
      rd <= 1'h0;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] lo, input logic [7:0] hi,
      input string m);
      checked++;
      if ((g >= lo && g <= hi) !== 1'h1) begin
         errors++;
         $display("unexpected at %0t: %s got %h", $time, m, g);
      end
   endtask

   task automatic rc(input logic [5:0] a, input logic [7:0] lo, input logic [7:0] hi,
      input string m);
      xfer(a, 1'h0, 8'h00);
      chk(q, lo, hi, m);
   endtask

   initial begin
      int i, k, e;
      repeat (12) @(posedge refClk);
      rst <= 1'h0;
      for (i = 0; i < 9; i++) rc(6'(i * 4), RST_V[i], RST_V[i], "reset value");
      xfer(OFS_CMP_A, 1'h1, 8'h5A);
      rc(OFS_CMP_A, 8'h5A, 8'h5A, "compare write");
      be <= 4'hE;
      xfer(OFS_CMP_A, 1'h1, 8'h33);
      be <= 4'hF;
      rc(OFS_CMP_A, 8'h5A, 8'h5A, "byte enable off");
      xfer(6'h24, 1'h1, 8'hFF);
      rc(6'h24, 8'h00, 8'h00, "unmapped");
      xfer(OFS_COUNTER, 1'h1, 8'h3C);
      rc(OFS_COUNTER, 8'h3C, 8'h3C, "counter write");
      // Internal taps: bit 2(k-1)+ic, about 204 cycles between start and stop
      for (k = 1; k < 5; k++) for (i = 0; i < 2; i++) begin
         xfer(OFS_CTRL_ONE, 1'h1, 8'(i));
         xfer(OFS_COUNTER, 1'h1, 8'h00);
         xfer(OFS_CTRL_ZERO, 1'h1, 8'(k));
         repeat (200) @(posedge refClk);
         xfer(OFS_CTRL_ZERO, 1'h1, 8'h00);
         e = 204 >> (2 * k - 1 + i);
         rc(OFS_COUNTER, 8'((e < 2) ? 0 : e - 2), 8'(e + 2), "internal rate");
      end
      for (k = 5; k < 8; k++) begin
         xfer(OFS_COUNTER, 1'h1, 8'h00);
         xfer(OFS_CTRL_ZERO, 1'h1, 8'(k));
         repeat (5) begin
            repeat (4) @(posedge refClk);
            extClk <= 1'h1;
            repeat (4) @(posedge refClk);
            extClk <= 1'h0;
         end
         repeat (6) @(posedge refClk);
         xfer(OFS_CTRL_ZERO, 1'h1, 8'h00);
         e = (k == 7) ? 10 : 5;
         rc(OFS_COUNTER, 8'(e), 8'(e + 1), "external edges");
      end
      xfer(OFS_CTRL_ONE, 1'h1, 8'h00);
      xfer(OFS_CMP_A, 1'h1, 8'h04);
      xfer(OFS_CMP_B, 1'h1, 8'h08);
      for (i = 0; i < 3; i++) begin
         xfer(OFS_COUNTER, 1'h1, 8'h00);
         xfer(OFS_STATUS, 1'h1, 8'hE0);
         xfer(OFS_CTRL_ZERO, 1'h1, 8'((2 - i) * 8 + 1) | IE_V[i]);
         repeat (600) @(posedge refClk);
         @(negedge refClk);
         chk({7'h00, irq}, 8'h01, 8'h01, "irq on event");
         xfer(OFS_CTRL_ZERO, 1'h1, 8'((2 - i) * 8));
         rc(OFS_STATUS, FLAGS_V[i], FLAGS_V[i], "event flags");
         rc(OFS_COUNTER, 8'h00, LIMIT_V[i], "clear point");
      end
      xfer(OFS_CTRL_ZERO, 1'h1, 8'h00);
      @(negedge refClk);
      chk({7'h00, irq}, 8'h00, 8'h00, "irq without enable");
      for (i = 0; i < 3; i++) begin
         xfer(OFS_CTRL_ZERO, 1'h1, IE_V[i]);
         @(negedge refClk);
         chk({7'h00, irq}, 8'h01, 8'h01, "irq enabled");
      end
      xfer(OFS_IRQ_MASK, 1'h1, 8'h00);
      @(negedge refClk);
      chk({7'h00, irq}, 8'h00, 8'h00, "irq masked");
      xfer(OFS_IRQ_MASK, 1'h1, 8'hE0);
      xfer(OFS_STATUS, 1'h1, 8'h20);
      @(negedge refClk);
      chk({7'h00, irq}, 8'h00, 8'h00, "irq after clear");
      rc(OFS_STATUS, 8'hC0, 8'hC0, "write one clears");
      xfer(OFS_CTRL_ZERO, 1'h1, 8'h18);
      xfer(OFS_COUNTER, 1'h1, 8'h80);
      rc(OFS_COUNTER, 8'h80, 8'h80, "no early clear");
      for (i = 0; i < 2; i++) begin
         if (i == 1) begin
            xfer(OFS_CTRL_ONE, 1'h1, 8'h02);
            xfer(OFS_CTRL_ZERO, 1'h1, 8'h19);
            repeat (40) @(posedge refClk);
            rc(OFS_COUNTER, 8'h00, 8'h00, "held until trigger");
         end
         @(posedge refClk);
         trig <= 1'h1;
         repeat (4) @(posedge refClk);
         trig <= 1'h0;
         repeat (i * 40 + 4) @(posedge refClk);
         rc(OFS_COUNTER, 8'h00, (i == 1) ? 8'h20 : 8'h00, "trigger clear");
      end
      chk(q, 8'h0A, 8'h20, "runs after trigger");
      xfer(OFS_CTRL_ONE, 1'h1, 8'h00);
      xfer(OFS_CTRL_ZERO, 1'h1, 8'h01);
      xfer(OFS_COUNTER, 1'h1, 8'h50);
      rc(OFS_COUNTER, 8'h50, 8'h53, "write beats count");
      xfer(OFS_CTRL_ZERO, 1'h1, 8'h00);
      xfer(OFS_CMP_A, 1'h1, 8'h06);
      xfer(OFS_CMP_B, 1'h1, 8'h06);
      for (i = 0; i < 3; i++) begin
         xfer(OFS_COUNTER, 1'h1, 8'h00);
         xfer(OFS_OUT_SEL, 1'h1, OSEL_V[i]);
         xfer(OFS_CTRL_ZERO, 1'h1, 8'h01);
         repeat (30) @(posedge refClk);
         xfer(OFS_CTRL_ZERO, 1'h1, 8'h00);
         chk({7'h00, tOut}, OUT_V[i], OUT_V[i], "output priority");
      end
      tally_and_finish();
   end
endmodule
